/* File: tx_pcs_pkg.sv */
// shared constants and types for the transmit pcs path
// assumes a single 25 MHz clock that stands for the serial bit clock
`default_nettype none
package tx_pcs_pkg;
    // code groups and xgmii characters
    localparam logic [7:0] K28_0   = 8'h1c;
    localparam logic [7:0] K28_3   = 8'h7c;
    localparam logic [7:0] K28_4   = 8'h9c;
    localparam logic [7:0] K28_5   = 8'hbc;
    localparam logic [7:0] K27_7   = 8'hfb;
    localparam logic [7:0] K29_7   = 8'hfd;
    localparam logic [7:0] K30_7   = 8'hfe;
    localparam logic [7:0] XG_IDLE = 8'h07;
    localparam logic [7:0] D21_5   = 8'hb5;
    localparam logic [7:0] D2_2    = 8'h42;
    localparam logic [7:0] D5_6    = 8'hc5;
    localparam logic [7:0] D16_2   = 8'h50;
    // idle randomiser and alignment spacing
    localparam logic [6:0] PRBS_SEED = 7'h01;
    localparam logic [4:0] A_MIN     = 5'h10;
    // pll lock after this many reference edges
    localparam logic [7:0] LOCK_EDGES = 8'h40;
    // fifo depth and serializer bit counts
    localparam logic [2:0] FIFO_DEPTH = 3'h4;
    localparam logic [3:0] SYM10_LAST = 4'h9;
    localparam logic [3:0] SYM8_LAST  = 4'h7;
    // valid multiplication factors
    localparam logic [4:0] MUL_2  = 5'h02;
    localparam logic [4:0] MUL_4  = 5'h04;
    localparam logic [4:0] MUL_5  = 5'h05;
    localparam logic [4:0] MUL_8  = 5'h08;
    localparam logic [4:0] MUL_10 = 5'h0a;
    localparam logic [4:0] MUL_16 = 5'h10;
    localparam logic [4:0] MUL_20 = 5'h14;

    typedef enum logic [1:0] {
        REF_PIN    = 2'h0,
        REF_FABRIC = 2'h1,
        REF_INTER  = 2'h2
    } ref_sel_t;

    // gigabit ethernet idle rewrite states
    typedef enum logic [1:0] {
        G_DATA  = 2'b01,
        G_IDLE2 = 2'b10
    } gst_t;

    typedef struct packed {
        ref_sel_t   ref_sel;
        logic       tx_used;
        logic [4:0] mult;
        logic       predivider;
    } pll_cfg_t;

    typedef struct packed {
        logic double_width;
        logic ten_bit;
        logic enc_bypass;
        logic xaui_mode;
        logic gigabit_ethernet_mode_idle_en;
    } cfg_t;

    typedef struct packed {
        logic [1:0]  c;
        logic [19:0] d;
    } fword_t;
endpackage
`default_nettype wire

/* File: enc_8b10b.sv */
// combinational 8b/10b encoder with running disparity in and out
// assumes the caller registers the disparity; bit 0 of code_o goes out first
`default_nettype none
module enc_8b10b
    import tx_pcs_pkg::*;
(
    input  wire logic [7:0] data_i,
    input  wire logic       ctrl_i,
    input  wire logic       rd_i,
    output logic      [9:0] code_o,
    output logic            rd_o
);
    // 5b/6b code for negative disparity, abcdei with a at the top
    function automatic logic [5:0] t6(input logic [4:0] x);
        case (x)
            5'h00: t6 = 6'h27;  5'h01: t6 = 6'h1d;  5'h02: t6 = 6'h2d;  5'h03: t6 = 6'h31;
            5'h04: t6 = 6'h35;  5'h05: t6 = 6'h29;  5'h06: t6 = 6'h19;  5'h07: t6 = 6'h38;
            5'h08: t6 = 6'h39;  5'h09: t6 = 6'h25;  5'h0a: t6 = 6'h15;  5'h0b: t6 = 6'h34;
            5'h0c: t6 = 6'h0d;  5'h0d: t6 = 6'h2c;  5'h0e: t6 = 6'h1c;  5'h0f: t6 = 6'h17;
            5'h10: t6 = 6'h1b;  5'h11: t6 = 6'h23;  5'h12: t6 = 6'h13;  5'h13: t6 = 6'h32;
            5'h14: t6 = 6'h0b;  5'h15: t6 = 6'h2a;  5'h16: t6 = 6'h1a;  5'h17: t6 = 6'h3a;
            5'h18: t6 = 6'h33;  5'h19: t6 = 6'h26;  5'h1a: t6 = 6'h16;  5'h1b: t6 = 6'h36;
            5'h1c: t6 = 6'h0e;  5'h1d: t6 = 6'h2e;  5'h1e: t6 = 6'h1e;  default: t6 = 6'h2b;
        endcase
    endfunction

    // 3b/4b data code for negative disparity, fghj with f at the top
    function automatic logic [3:0] t4(input logic [2:0] y);
        case (y)
            3'h0: t4 = 4'hb;  3'h1: t4 = 4'h9;  3'h2: t4 = 4'h5;  3'h3: t4 = 4'hc;
            3'h4: t4 = 4'hd;  3'h5: t4 = 4'ha;  3'h6: t4 = 4'h6;  default: t4 = 4'he;
        endcase
    endfunction

    // 3b/4b code of control groups after a negative start
    function automatic logic [3:0] tk(input logic [2:0] y);
        case (y)
            3'h0: tk = 4'h4;  3'h1: tk = 4'h9;  3'h2: tk = 4'h5;  3'h3: tk = 4'h3;
            3'h4: tk = 4'h2;  3'h5: tk = 4'ha;  3'h6: tk = 4'h6;  default: tk = 4'h8;
        endcase
    endfunction

    logic [4:0] x;
    logic [2:0] y;
    logic       kv;
    logic       rdm;
    logic [5:0] s6;
    logic [3:0] s4;
    logic [9:0] cat;

    // disparity choice per sub-block, then reverse so a leaves first
    always_comb
    begin
        x   = data_i[4:0];
        y   = data_i[7:5];
        kv  = ctrl_i && (x == 5'h1c || (y == 3'h7 &&
              (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e)));
        s6  = (kv && x == 5'h1c) ? 6'h0f : t6(x);
        s4  = t4(y);
        rdm = rd_i ^ ($countones(s6) != 3);
        if (kv)
        begin
            cat = {s6, tk(y)};
            if (rd_i)
                cat = ~cat;
        end
        else
        begin
            if (rd_i && ($countones(s6) != 3 || x == 5'h07))
                s6 = ~s6;
            if (y == 3'h7 && ((!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                              (rdm && (x == 5'h0b || x == 5'h0d || x == 5'h0e))))
                s4 = 4'h7;                                  // alternate .7 against runs
            if (rdm && ($countones(s4) != 2 || y == 3'h3))
                s4 = ~s4;
            cat = {s6, s4};
        end
        for (int i = 0; i < 10; i++)
            code_o[i] = cat[9 - i];
        rd_o = rd_i ^ ($countones(cat) != 5);
    end
endmodule
`default_nettype wire

/* File: tx_pcs_path.sv */
// transmit path: pll lock model, phase fifo, byte serializer, idle
// rewrite, 8b/10b and lsb-first serializer
// assumes clk_i is the serial bit clock; reference inputs are async pins
`default_nettype none
// Function
// - pll yields serial, receiver and fabric clocks
// - one reference, chosen from three sources
// - pll off when no transmit channel used
// - optional pll locked flag
// - factors two and five need pin predivider
// - four-word fifo always in path
// - double width words split into two symbols
// - single width words pass straight through
// - byte plus control bit becomes code group
// - serial run never exceeds five bits when encoded
// - encoder bypass passes words unencoded
// - protocol selects xaui or gigabit ethernet
// - ethernet idles rewritten as i1 or i2
// - configuration sets kept, never produced
// - every ethernet idle ends negative disparity
// - ethernet idle rewrite can be disabled
// - xaui control characters map to k codes
// - xaui idles randomised k28.0/k28.5 by prbs7
// - k28.3 every 16 to 31 idles
// - idle randomisation needs no fabric action
// - serializer sends least significant bit first
module tx_pcs_path
    import tx_pcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        dedicated_ref_pin_i,
    input  wire logic        fabric_ref_i,
    input  wire logic        inter_ref_i,
    input  wire pll_cfg_t    pll_cfg_i,
    input  wire cfg_t        cfg_i,
    input  wire logic        wr_valid_i,
    input  wire logic [19:0] wr_data_i,
    input  wire logic [1:0]  wr_ctrl_i,
    output logic             wr_ready_o,
    output logic             ser_o,
    output logic             fabric_tick_o,
    output logic             rx_ref_tick_o,
    output logic             pll_on_o,
    output logic             pll_locked_o,
    output logic             mult_err_o
);
    typedef struct packed {
        logic [2:0]      s1;
        logic [2:0]      s2;
        logic [2:0]      s3;
        logic [7:0]      lock_cnt;
        logic            locked;
        logic            pll_on;
        logic            merr;
        logic [3:0][21:0] mem;
        logic [1:0]      wp;
        logic [1:0]      rp;
        logic [2:0]      cnt;
        logic            rdy;
        logic            half;
        logic            rd;
        logic [6:0]      prbs;
        logic [4:0]      icnt;
        logic [4:0]      atgt;
        gst_t            gst;
        logic [9:0]      sh;
        logic [3:0]      bitcnt;
        logic            ser;
        logic            ftick;
        logic            rtick;
        logic [2:0]      run;
    } st_t;

    st_t        st;
    st_t        n;
    logic       redge;
    logic       push;
    logic       pop;
    logic       load;
    logic       avail;
    logic       conv;
    fword_t     head;
    logic [9:0] raw;
    logic [7:0] bb;
    logic       kk;
    logic [9:0] code;
    logic [9:0] ecode;
    logic       rd_nx;

    // multiplication factor check, low factors only through the pin divider
    function automatic logic mult_ok(input pll_cfg_t p);
        case (p.mult)
            MUL_4, MUL_8, MUL_10, MUL_16, MUL_20: mult_ok = 1'b1;
            MUL_2, MUL_5: mult_ok = p.predivider && p.ref_sel == REF_PIN;
            default: mult_ok = 1'b0;
        endcase
    endfunction

    enc_8b10b u_enc (
        .data_i (bb),
        .ctrl_i (kk),
        .rd_i   (st.rd),
        .code_o (ecode),
        .rd_o   (rd_nx)
    );

    // next-state logic for the whole path
    always_comb
    begin
        n     = st;
        n.s1  = {inter_ref_i, fabric_ref_i, dedicated_ref_pin_i};
        n.s2  = st.s1;
        n.s3  = st.s2;
        // single reference input from the selected source
        case (pll_cfg_i.ref_sel)
            REF_PIN:    redge = st.s2[0] & ~st.s3[0];
            REF_FABRIC: redge = st.s2[1] & ~st.s3[1];
            REF_INTER:  redge = st.s2[2] & ~st.s3[2];
            default:    redge = 1'b0;
        endcase
        n.merr   = !mult_ok(pll_cfg_i);
        n.pll_on = pll_cfg_i.tx_used;
        if (!pll_cfg_i.tx_used || n.merr)
        begin
            n.lock_cnt = '0;
            n.locked   = 1'b0;
        end
        else if (redge && !st.locked)
        begin
            n.lock_cnt = st.lock_cnt + 8'h01;
            n.locked   = (st.lock_cnt == LOCK_EDGES - 8'h01);
        end
        // phase compensation fifo, never bypassed
        push  = wr_valid_i && st.rdy;
        avail = (st.cnt != 3'h0);
        head  = st.mem[st.rp];
        load  = st.locked && (st.bitcnt == 4'h0);
        pop   = load && avail && (!cfg_i.double_width || st.half);
        if (push)
        begin
            n.mem[st.wp] = {wr_ctrl_i, wr_data_i};
            n.wp         = st.wp + 2'h1;
        end
        if (pop)
            n.rp = st.rp + 2'h1;
        n.cnt = st.cnt + {2'h0, push} - {2'h0, pop};
        n.rdy = (n.cnt != FIFO_DEPTH);
        if (load && avail)
            n.half = cfg_i.double_width && !st.half;
        // lane select: lower half first, raw 10-bit lanes only in bypass
        if (cfg_i.enc_bypass && cfg_i.ten_bit)
            raw = st.half ? head.d[19:10] : head.d[9:0];
        else
            raw = {2'h0, st.half ? head.d[15:8] : head.d[7:0]};
        bb   = raw[7:0];
        kk   = head.c[st.half];
        conv = 1'b0;
        if (!avail)
        begin
            bb = cfg_i.xaui_mode ? XG_IDLE : K28_5;                     // filler on underrun
            kk = 1'b1;
            raw = {2'h0, bb};
        end
        // protocol state machine, only with the encoder in the path
        if (!cfg_i.enc_bypass && cfg_i.xaui_mode)
        begin
            if (kk)
            begin
                case (bb)
                    XG_IDLE:
                    begin
                        if (load)
                        begin
                            n.prbs = {st.prbs[5:0], st.prbs[6] ^ st.prbs[5]};
                            n.icnt = st.icnt + 5'h01;
                        end
                        if (st.icnt >= st.atgt)
                        begin
                            bb = K28_3;
                            if (load)
                            begin
                                n.icnt = '0;
                                n.atgt = {1'b1, st.prbs[3:0]};
                            end
                        end
                        else
                            bb = st.prbs[0] ? K28_5 : K28_0;
                    end
                    K28_4, K27_7, K29_7, K30_7: bb = bb;
                    default: bb = K30_7;
                endcase
            end
        end
        else if (!cfg_i.enc_bypass && cfg_i.gigabit_ethernet_mode_idle_en)
        begin
            case (st.gst)
                G_IDLE2:
                begin
                    if (!kk && bb != D21_5 && bb != D2_2)
                    begin
                        bb   = st.rd ? D16_2 : D5_6;
                        conv = 1'b1;
                    end
                    if (load)
                        n.gst = (kk && bb == K28_5) ? G_IDLE2 : G_DATA;
                end
                G_DATA:
                    if (load && kk && bb == K28_5)
                        n.gst = G_IDLE2;
                default: n.gst = G_DATA;
            endcase
        end
        else
            n.gst = G_DATA;
        code = cfg_i.enc_bypass ? raw : ecode;
        // serializer, lsb first
        if (!st.locked)
        begin
            n.bitcnt = '0;
            n.ser    = 1'b0;
            n.sh     = '0;
        end
        else if (load)
        begin
            n.ser    = code[0];
            n.sh     = {1'b0, code[9:1]};
            n.bitcnt = (cfg_i.enc_bypass && !cfg_i.ten_bit) ? SYM8_LAST : SYM10_LAST;
            if (!cfg_i.enc_bypass)
                n.rd = rd_nx;
        end
        else
        begin
            n.ser    = st.sh[0];
            n.sh     = {1'b0, st.sh[9:1]};
            n.bitcnt = st.bitcnt - 4'h1;
        end
        // derived slow clocks: fabric tick halves in double width
        n.rtick = load;
        n.ftick = pop;
        // run length monitor of the encoded stream
        if (!st.locked || cfg_i.enc_bypass)
            n.run = '0;
        else if (st.run != 3'h0 && n.ser == st.ser && st.run != 3'h7)
            n.run = st.run + 3'h1;
        else
            n.run = 3'h1;
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st      <= '0;
            st.prbs <= PRBS_SEED;
            st.atgt <= A_MIN;
            st.gst  <= G_DATA;
        end
        else
            st <= n;
    end

    // outputs straight from the state register
    assign wr_ready_o    = st.rdy;
    assign ser_o         = st.ser;
    assign fabric_tick_o = st.ftick;
    assign rx_ref_tick_o = st.rtick;
    assign pll_on_o      = st.pll_on;
    assign pll_locked_o  = st.locked;
    assign mult_err_o    = st.merr;

    property p_fifo_depth;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> (st.cnt <= FIFO_DEPTH) && (wr_ready_o == (st.cnt != FIFO_DEPTH));
    endproperty
    a_fifo_depth: assert property (p_fifo_depth)
        else $error("fifo count or ready wrong");

    property p_off_unlocked;
        @(posedge clk_i) disable iff (rst_i)
        !pll_cfg_i.tx_used |=> !pll_locked_o && !pll_on_o;
    endproperty
    a_off_unlocked: assert property (p_off_unlocked)
        else $error("pll locked while powered off");

    property p_low_factor;
        @(posedge clk_i) disable iff (rst_i)
        (pll_cfg_i.mult == MUL_5 && !pll_cfg_i.predivider) |=> mult_err_o ##1 !pll_locked_o;
    endproperty
    a_low_factor: assert property (p_low_factor)
        else $error("factor five accepted without predivider");

    property p_run_limit;
        @(posedge clk_i) disable iff (rst_i)
        st.run <= 3'h5;
    endproperty
    a_run_limit: assert property (p_run_limit)
        else $error("run length above five");

    property p_lsb_first;
        @(posedge clk_i) disable iff (rst_i)
        (load && !cfg_i.enc_bypass) |=> ser_o == $past(ecode[0]) ##1 ser_o == $past(ecode[1], 2);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("serial order not lsb first");

    property p_double_pop;
        @(posedge clk_i) disable iff (rst_i)
        (fabric_tick_o && $past(cfg_i.double_width)) |-> $past(st.half);
    endproperty
    a_double_pop: assert property (p_double_pop)
        else $error("double word popped before upper half");

    property p_single_pop;
        @(posedge clk_i) disable iff (rst_i)
        (load && avail && !cfg_i.double_width) |=> fabric_tick_o && rx_ref_tick_o;
    endproperty
    a_single_pop: assert property (p_single_pop)
        else $error("single width word not passed");

    property p_idle_neg;
        @(posedge clk_i) disable iff (rst_i)
        (load && conv) |=> !st.rd;
    endproperty
    a_idle_neg: assert property (p_idle_neg)
        else $error("idle set did not end negative");

    property p_align_gap;
        @(posedge clk_i) disable iff (rst_i)
        (load && cfg_i.xaui_mode && !cfg_i.enc_bypass && kk && bb == K28_3)
            |-> st.icnt >= A_MIN;
    endproperty
    a_align_gap: assert property (p_align_gap)
        else $error("alignment group too early");

    property p_reset_state;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !st.rd && st.prbs != 7'h00;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("bad disparity or seed after reset");
endmodule
`default_nettype wire

/* File: tx_link_rx_model.sv */
// far-end serial receiver: frames code groups off the line
// assumes the symbol tick marks the cycle that carries bit 0
`default_nettype none
module tx_link_rx_model
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ser_i,
    input  wire logic sym_tick_i,
    input  wire logic pop_tick_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] codes[$];
    bit         pops[$];
    logic [9:0] sh;
    logic       last;
    bit         pop_q;
    int         idx = 10;
    int         run = 0;
    int         max_run = 0;
    // gather ten bits from the tick, first bit into bit 0
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            codes.delete();
            pops.delete();
            idx = 10;
            run = 0;
            max_run = 0;
        end
        else
        begin
            if (sym_tick_i === 1'b1)
            begin
                idx = 0;
                pop_q = pop_tick_i;
            end
            if (idx < 10)
            begin
                sh[idx] = ser_i;
                idx++;
                run = (ser_i === last) ? run + 1 : 1;
                last = ser_i;
                if (run > max_run) max_run = run;
                if (idx == 10) codes.push_back(sh);
                if (idx == 10) pops.push_back(pop_q);
            end
        end
    end
endmodule
`default_nettype wire

/* File: serdes_transmit_pcs_path_test.sv */
// self-checking bench: fabric words in, code groups framed off the line
// assumes tx_pcs_pkg, the design and tx_link_rx_model compiled first
`default_nettype none
module serdes_transmit_pcs_path_test
    import tx_pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic [2:0]  ref_div = 0;
    pll_cfg_t    pcfg = '{REF_FABRIC, 1'b1, MUL_4, 1'b0};
    cfg_t        cfg = '0;
    logic        wr_valid = 0;
    logic [19:0] wr_data = 0;
    logic [1:0]  wr_ctrl = 0;
    logic        wr_ready, ser, fab_tick, rx_tick, pll_on, pll_locked, mult_err;
    int          num_errors = 0;
    int          check_count = 0;
    logic [9:0]  exp_q[$];
    int          rdq[$];
    always #20 clk_i = ~clk_i;
    // reference clock stand-ins
    always @(posedge clk_i) ref_div <= ref_div + 3'h1;
    tx_pcs_path DUT (.clk_i(clk_i), .rst_i(rst_i), .dedicated_ref_pin_i(ref_div[1]),
        .fabric_ref_i(ref_div[1]), .inter_ref_i(ref_div[2]), .pll_cfg_i(pcfg),
        .cfg_i(cfg), .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ctrl_i(wr_ctrl),
        .wr_ready_o(wr_ready), .ser_o(ser), .fabric_tick_o(fab_tick),
        .rx_ref_tick_o(rx_tick), .pll_on_o(pll_on), .pll_locked_o(pll_locked),
        .mult_err_o(mult_err));
    tx_link_rx_model rx (.clk_i(clk_i), .rst_i(rst_i), .ser_i(ser), .sym_tick_i(rx_tick),
        .pop_tick_i(fab_tick));
    // code group from abcdeifghj text, complemented for positive disparity
    function automatic logic [9:0] cg(input logic [9:0] s, input int rd);
        logic [9:0] v;
        v = {<<{s}};
        return (rd < 0) ? v : ~v;
    endfunction
    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok)
        begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic start(input cfg_t c);
        rst_i <= 1'b1;
        cfg <= c;
        pcfg <= '{REF_FABRIC, 1'b1, MUL_4, 1'b0};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic lock_wait();
        int n;
        n = 0;
        repeat (230) @(posedge clk_i);
        chk(pll_locked === 1'b0 && pll_on === 1'b1, "early lock");
        while (pll_locked !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(pll_locked === 1'b1, "no lock");
    endtask
    // fabric write, held until the fifo takes it
    task automatic put(input logic [19:0] d, input logic [1:0] c);
        int n;
        n = 0;
        wr_valid <= 1'b1;
        wr_data <= d;
        wr_ctrl <= c;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wr_ready !== 1'b1 && n < 500);
        chk(n < 500, "write stuck");
    endtask
    // running disparity walk over every framed group
    task automatic walk();
        int rd;
        int n1;
        rd = -1;
        rdq.delete();
        foreach (rx.codes[i])
        begin
            n1 = $countones(rx.codes[i]);
            rdq.push_back(rd);
            chk(n1 == 5 || (n1 == 6 && rd < 0) || (n1 == 4 && rd > 0), "disparity");
            if (n1 != 5) rd = -rd;
        end
        chk(rx.max_run <= 5, "run length");
    endtask
    task automatic bypass_run(input bit dw);
        logic [19:0] w;
        int          k;
        k = 0;
        exp_q.delete();
        start('{dw, 1'b1, 1'b1, 1'b0, 1'b0});
        for (int i = 0; i < 12; i++)
        begin
            w = 20'($urandom);
            put(w, 2'($urandom));
            exp_q.push_back(w[9:0]);
            if (dw) exp_q.push_back(w[19:10]);
            if (i == 3)
            begin
                wr_valid <= 1'b0;
                repeat (2) @(posedge clk_i);
                @(negedge clk_i);
                chk(wr_ready === 1'b0, "fifo depth");
                lock_wait();
            end
        end
        wr_valid <= 1'b0;
        repeat (300) @(posedge clk_i);
        foreach (rx.codes[i])
            if (rx.pops[i])
            begin
                if (dw) chk(rx.codes[i - 1] === exp_q[k++], "low half");
                chk(rx.codes[i] === exp_q[k++], "word");
            end
        chk(k == exp_q.size(), "word count");
    endtask
    task automatic gigabit_ethernet_mode_run(input bit en);
        logic [8:0] pat[8] = '{9'h1bc, 0, 0, 9'h1bc, 9'h0b5, 9'h1bc, 9'h042, 9'h1bc};
        logic [8:0] v;
        logic [9:0] c;
        bit         kpos;
        int         ni;
        int         nc;
        ni = 0;
        nc = 0;
        start('{1'b0, 1'b0, 1'b0, 1'b0, en});
        lock_wait();
        for (int i = 0; i < 32; i++)
        begin
            v = (pat[i % 8] == 9'h0) ? 9'($urandom_range(1, 63)) : pat[i % 8];
            put({12'h0, v[7:0]}, {1'b0, v[8]});
        end
        wr_valid <= 1'b0;
        repeat (300) @(posedge clk_i);
        walk();
        for (int i = 1; i + 1 < rx.codes.size(); i++)
        begin
            c = rx.codes[i];
            kpos = rdq[i - 1] > 0;
            if (rx.codes[i - 1][5:0] !== 6'h3c && rx.codes[i - 1][5:0] !== 6'h03)
                continue;
            if (c === cg(10'b1010101010, -1)
                || c === cg(kpos ? 10'b1011010101 : 10'b0100100101, -1))
                nc++;
            else if (c[5:0] !== 6'h3c && c[5:0] !== 6'h03)
            begin
                ni++;
                chk((c === cg(kpos ? 10'b1010010110 : 10'b1001000101, -1)) == en, "idle");
                if (en) chk(rdq[i + 1] < 0, "idle end");
            end
        end
        chk(nc == 8 && ni >= 4, "ordered sets");
    endtask
    task automatic xaui_run();
        logic [9:0] kt[6] = '{10'b0011110010, 10'b1101101000, 10'b1011101000,
            10'b0111101000, 10'b0111101000, 10'b1010100101};
        logic [7:0] ch[6] = '{8'h9c, 8'hfb, 8'hfd, 8'hfe, 8'h33, 8'h55};
        logic [9:0] c;
        bit         b0;
        bit         b5;
        int         j;
        int         gap;
        int         na;
        int         nk0;
        int         nk5;
        j = 0;
        gap = 0;
        na = 0;
        nk0 = 0;
        nk5 = 0;
        start('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
        lock_wait();
        foreach (ch[i]) put({12'h0, ch[i]}, {1'b0, i < 5});
        wr_valid <= 1'b0;
        repeat (1200) @(posedge clk_i);
        walk();
        foreach (rx.codes[i])
        begin
            c = rx.codes[i];
            b0 = c === cg(10'b0011110100, rdq[i]);
            b5 = c === cg(10'b0011111010, rdq[i]);
            if (j < 6)
            begin
                if (rx.pops[i]) chk(c === cg(kt[j], (j == 5) ? -1 : rdq[i]), "map");
                if (rx.pops[i]) j++;
            end
            else if (c === cg(10'b0011110011, rdq[i]))
            begin
                if (na > 0) chk(gap >= 16 && gap <= 31, "align spacing");
                na++;
                gap = 0;
            end
            else
            begin
                gap++;
                nk0 += b0;
                nk5 += b5;
                chk(b0 || b5, "idle code");
            end
        end
        chk(na >= 2 && nk0 > 0 && nk5 > 0, "idle mix");
    endtask
    task automatic pll_run();
        logic [4:0] fac[8] = '{MUL_2, MUL_4, MUL_5, MUL_8, MUL_10, MUL_16, MUL_20, 5'h03};
        bit         bad;
        start('{1'b0, 1'b1, 1'b1, 1'b0, 1'b0});
        lock_wait();
        foreach (fac[i])
        begin
            bad = fac[i] == MUL_2 || fac[i] == MUL_5 || fac[i] == 5'h03;
            pcfg <= '{REF_FABRIC, 1'b1, fac[i], 1'b0};
            repeat (3) @(posedge clk_i);
            chk(mult_err === bad, "factor");
            if (bad) chk(pll_locked === 1'b0, "lock kept");
        end
        pcfg <= '{REF_PIN, 1'b1, MUL_5, 1'b1};
        lock_wait();
        pcfg <= '{REF_PIN, 1'b0, MUL_5, 1'b1};
        repeat (3) @(posedge clk_i);
        chk(pll_on === 1'b0 && pll_locked === 1'b0, "pll off");
        pcfg <= '{ref_sel_t'(2'h3), 1'b1, MUL_4, 1'b0};
        repeat (400) @(posedge clk_i);
        chk(pll_on === 1'b1 && pll_locked === 1'b0, "no source");
        pcfg <= '{REF_INTER, 1'b1, MUL_4, 1'b0};
        repeat (600) @(posedge clk_i);
        chk(pll_locked === 1'b1, "inter source");
    endtask
    // watchdog well beyond the expected run
    initial
    begin
        #(40 * 30000);
        num_errors++;
        end_sim();
    end
    initial
    begin
        void'($urandom(96616));
        bypass_run(1'b0);
        bypass_run(1'b1);
        gigabit_ethernet_mode_run(1'b1);
        gigabit_ethernet_mode_run(1'b0);
        xaui_run();
        pll_run();
        end_sim();
    end
endmodule
`default_nettype wire
